/* File: inc/endpoint2_control_regs.svh */
`ifndef ENDPOINT2_CONTROL_REGS_SVH
`define ENDPOINT2_CONTROL_REGS_SVH
`define ENDPOINT2_CONTROL_OFFSET 8'hB4
`define INT_STATUS_OFFSET 8'hB8
`define INT_MASK_OFFSET 8'hBC
`define RD_COUNT_A_OFFSET 8'hC0
`define RD_COUNT_B_OFFSET 8'hC4
`define ENDPOINT2_CONTROL_RESET 8'h00
`define BIT_DIR 7
`define BIT_WR_TOGGLE_GATE 6
`define BIT_WR_TOGGLE 5
`define BIT_RD_SELECT 4
`define BIT_STALL_RX 3
`define BIT_STALL_TX 2
`define BIT_RD_GATE 1
`define BIT_ENABLE 0
`define IRQ_DONE_A 0
`define IRQ_DONE_B 1
`define BUF_BYTES 512
`endif

/* File: inc/ep2_pkg.sv */
package ep2_pkg;
  typedef enum logic [1:0]
  {
    RD_IDLE = 2'b00,
    RD_RUN = 2'b01,
    RD_LAST = 2'b10
  } rd_state_t;
  typedef logic [9:0] count_t;
endpackage

/* File: inc/stall_if.sv */
`timescale 1ns/1ps
interface stall_if;
  logic set_rx;
  logic set_tx;
  logic clr_rx;
  logic clr_tx;
  logic stall_rx;
  logic stall_tx;
  modport ctl (input set_rx, input set_tx, input clr_rx, input clr_tx, output stall_rx, output stall_tx);
  modport src (output set_rx, output set_tx, output clr_rx, output clr_tx, input stall_rx, input stall_tx);
endinterface

/* File: verilog/ep2_stall.sv */
`timescale 1ns/1ps
module ep2_stall
(
  input wire logic clk_i,
  input wire logic nrst_i,
  stall_if.ctl s
);
  import ep2_pkg::*;
  logic rx_q;
  logic tx_q;
  assign s.stall_rx = rx_q;
  assign s.stall_tx = tx_q;
  // sticky receive halt, clear events; set wins
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rx_q <= 1'b0;
    else if (s.set_rx)
      rx_q <= 1'b1;
    else if (s.clr_rx)
      rx_q <= 1'b0;
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tx_q <= 1'b0;
    else if (s.set_tx)
      tx_q <= 1'b1;
    else if (s.clr_tx)
      tx_q <= 1'b0;
  end
endmodule // ep2_stall

/* File: verilog/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync
#(
  parameter int W = 1
)
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_q;
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : bit_g
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          q_q[g] <= 1'b0;
        end
        else
        begin
          s1_q[g] <= d_i[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          // Accept once stages two and three agree
          if (s2_q[g] == s3_q[g])
            q_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate
  assign q_o = q_q;
endmodule // pin_sync

/* File: verilog/ep2_read_ctl.sv */
`timescale 1ns/1ps
`include "endpoint2_control_regs.svh"
module ep2_read_ctl
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic engine_ep_enabled_i,
  input wire logic engine_set_stall_rx_i,
  input wire logic engine_set_stall_tx_i,
  input wire logic ep0_clear_feature_rx_i,
  input wire logic ep0_clear_feature_tx_i,
  input wire logic ep0_set_config_i,
  input wire logic usb_reset_i,
  input wire logic token_rx_i,
  input wire logic token_tx_i,
  input wire logic rd_ready_i,
  output logic stall_handshake_rx_o,
  output logic stall_handshake_tx_o,
  output logic stall_rx_o,
  output logic stall_tx_o,
  output logic rd_buf_sel_o,
  output logic [8:0] rd_addr_o,
  output logic rd_valid_engine_o,
  output logic rd_valid_ata_o,
  output logic flow_dir_o,
  output logic wr_toggle_o,
  output logic read_done_a_o,
  output logic read_done_b_o,
  output logic irq_o
);
  import ep2_pkg::*;
  stall_if st ();
  logic [8:0] ep_sync;
  logic dir_q;
  logic wr_tog_q;
  logic sel_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  count_t cnt_a_q;
  count_t cnt_b_q;
  count_t pos_q;
  rd_state_t state_q;
  rd_state_t state_d;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic wait_q;
  logic hs_rx_q;
  logic hs_tx_q;
  logic [8:0] addr_q;
  logic vs_q;
  logic va_q;
  logic irq_q;
  logic pend_q;
  // Engine-side strobes come from another domain
  pin_sync #(.W(9)) u_sync
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .d_i({engine_ep_enabled_i, engine_set_stall_rx_i, engine_set_stall_tx_i, ep0_clear_feature_rx_i,
      ep0_clear_feature_tx_i, ep0_set_config_i, usb_reset_i, token_rx_i, token_tx_i}),
    .q_o(ep_sync)
  );
  logic ep_en;
  logic s_set_rx;
  logic s_set_tx;
  logic s_clr_rx;
  logic s_clr_tx;
  logic s_cfg;
  logic s_rst;
  logic s_tok_rx;
  logic s_tok_tx;
  logic [8:0] ep_prev_q;
  logic [8:0] ep_rise;
  assign ep_rise = ep_sync & ~ep_prev_q;
  assign ep_en = ep_sync[8];
  assign s_set_rx = ep_rise[7];
  assign s_set_tx = ep_rise[6];
  assign s_clr_rx = ep_rise[5];
  assign s_clr_tx = ep_rise[4];
  assign s_cfg = ep_rise[3];
  assign s_rst = ep_rise[2];
  assign s_tok_rx = ep_rise[1];
  assign s_tok_tx = ep_rise[0];
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction
  logic acc;
  logic wr_ctl;
  logic wr_sts;
  logic wr_msk;
  logic wr_ca;
  logic wr_cb;
  logic mapped;
  logic sel_wr;
  logic start;
  logic cur_done;
  logic [7:0] ctl_read;
  // One access at a time, answered next cycle
  assign acc = (avs_read_i | avs_write_i) & wait_q & ~pend_q;
  assign mapped = hit(avs_address_i, `ENDPOINT2_CONTROL_OFFSET) | hit(avs_address_i, `INT_STATUS_OFFSET)
    | hit(avs_address_i, `INT_MASK_OFFSET) | hit(avs_address_i, `RD_COUNT_A_OFFSET)
    | hit(avs_address_i, `RD_COUNT_B_OFFSET);
  assign wr_ctl = acc & avs_write_i & avs_byteenable_i[0] & hit(avs_address_i, `ENDPOINT2_CONTROL_OFFSET);
  assign wr_sts = acc & avs_write_i & avs_byteenable_i[0] & hit(avs_address_i, `INT_STATUS_OFFSET);
  assign wr_msk = acc & avs_write_i & avs_byteenable_i[0] & hit(avs_address_i, `INT_MASK_OFFSET);
  assign wr_ca = acc & avs_write_i & hit(avs_address_i, `RD_COUNT_A_OFFSET);
  assign wr_cb = acc & avs_write_i & hit(avs_address_i, `RD_COUNT_B_OFFSET);
  // Direction as this edge leaves it
  logic dir_d;
  assign dir_d = wr_ctl ? avs_writedata_i[`BIT_DIR] : dir_q;
  // select applied only with gate bit
  assign sel_wr = wr_ctl & avs_writedata_i[`BIT_RD_GATE];
  assign start = sel_wr;
  assign cur_done = (pos_q + 10'h001) >= (sel_q ? cnt_b_q : cnt_a_q);
  assign ctl_read = {dir_q, 1'b0, wr_tog_q, sel_q, st.stall_rx, st.stall_tx, 1'b0, ep_en};
  // Stall sources; firmware writes of one set
  assign st.set_rx = s_set_rx | (wr_ctl & avs_writedata_i[`BIT_STALL_RX]);
  assign st.set_tx = s_set_tx | (wr_ctl & avs_writedata_i[`BIT_STALL_TX]);
  assign st.clr_rx = s_clr_rx | s_cfg | s_rst;
  assign st.clr_tx = s_clr_tx | s_cfg | s_rst;
  ep2_stall u_stall
  (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .s(st)
  );
  // Previous synced levels for edge detect
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      ep_prev_q <= 9'h000;
    else
      ep_prev_q <= ep_sync;
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dir_q <= 1'b0;
      wr_tog_q <= 1'b0;
    end
    else if (wr_ctl)
    begin
      dir_q <= avs_writedata_i[`BIT_DIR];
      if (avs_writedata_i[`BIT_WR_TOGGLE_GATE])
        wr_tog_q <= avs_writedata_i[`BIT_WR_TOGGLE];
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sel_q <= 1'b0;
    else if (sel_wr)
      sel_q <= avs_writedata_i[`BIT_RD_SELECT];
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_a_q <= 10'h000;
      cnt_b_q <= 10'h000;
      mask_q <= 2'h0;
    end
    else
    begin
      if (wr_ca)
        cnt_a_q <= avs_writedata_i[9:0];
      if (wr_cb)
        cnt_b_q <= avs_writedata_i[9:0];
      if (wr_msk)
        mask_q <= avs_writedata_i[1:0];
    end
  end
  logic set_a;
  logic set_b;
  logic clr_a;
  logic clr_b;
  logic beat;
  assign beat = (state_q == RD_RUN) & rd_ready_i;
  // Next byte index; address follows it
  count_t pos_d;
  assign pos_d = start ? 10'h000 : (beat ? pos_q + 10'h001 : pos_q);
  // Count zero ends at once, no bytes
  rd_state_t launch_st;
  assign launch_st = ((avs_writedata_i[`BIT_RD_SELECT] ? cnt_b_q : cnt_a_q) == 10'h000) ? RD_LAST : RD_RUN;
  assign set_a = beat & cur_done & ~sel_q;
  assign set_b = beat & cur_done & sel_q;
  assign clr_a = (sel_wr & ~avs_writedata_i[`BIT_RD_SELECT]) | (wr_sts & avs_writedata_i[`IRQ_DONE_A]);
  assign clr_b = (sel_wr & avs_writedata_i[`BIT_RD_SELECT]) | (wr_sts & avs_writedata_i[`IRQ_DONE_B]);
  // Set wins over clear
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      status_q <= 2'h0;
    else
    begin
      status_q[`IRQ_DONE_A] <= set_a | (status_q[`IRQ_DONE_A] & ~clr_a);
      status_q[`IRQ_DONE_B] <= set_b | (status_q[`IRQ_DONE_B] & ~clr_b);
    end
  end
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RD_IDLE:
        if (start)
          state_d = launch_st;
      RD_RUN:
        if (start)
          state_d = launch_st;
        else if (beat & cur_done)
          state_d = RD_LAST;
      RD_LAST:
        state_d = start ? launch_st : RD_IDLE;
      default:
        state_d = RD_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= RD_IDLE;
      pos_q <= 10'h000;
    end
    else
    begin
      state_q <= state_d;
      pos_q <= pos_d;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      addr_q <= 9'h000;
      vs_q <= 1'b0;
      va_q <= 1'b0;
    end
    else
    begin
      addr_q <= pos_d[8:0];
      vs_q <= (state_d == RD_RUN) & dir_d;
      va_q <= (state_d == RD_RUN) & ~dir_d;
    end
  end
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hs_rx_q <= 1'b0;
      hs_tx_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      hs_rx_q <= s_tok_rx & st.stall_rx;
      hs_tx_q <= s_tok_tx & st.stall_tx;
      irq_q <= |(status_q & mask_q);
    end
  end
  // Bus slave: one wait cycle, then answer
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wait_q <= 1'b1;
      pend_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'h0;
    end
    else
    begin
      wait_q <= ~acc;
      pend_q <= acc;
      if (acc)
      begin
        resp_q <= mapped ? 2'h0 : 2'h3;
        if (hit(avs_address_i, `ENDPOINT2_CONTROL_OFFSET))
          rdata_q <= {24'h00_0000, ctl_read};
        else if (hit(avs_address_i, `INT_STATUS_OFFSET))
          rdata_q <= {30'h0000_0000, status_q};
        else if (hit(avs_address_i, `INT_MASK_OFFSET))
          rdata_q <= {30'h0000_0000, mask_q};
        else if (hit(avs_address_i, `RD_COUNT_A_OFFSET))
          rdata_q <= {22'h00_0000, cnt_a_q};
        else if (hit(avs_address_i, `RD_COUNT_B_OFFSET))
          rdata_q <= {22'h00_0000, cnt_b_q};
        else
          rdata_q <= 32'h0000_0000;
      end
    end
  end
  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign avs_response_o = resp_q;
  assign stall_handshake_rx_o = hs_rx_q;
  assign stall_handshake_tx_o = hs_tx_q;
  assign stall_rx_o = st.stall_rx;
  assign stall_tx_o = st.stall_tx;
  assign rd_buf_sel_o = sel_q;
  assign rd_addr_o = addr_q;
  assign rd_valid_engine_o = vs_q;
  assign rd_valid_ata_o = va_q;
  assign flow_dir_o = dir_q;
  assign wr_toggle_o = wr_tog_q;
  assign read_done_a_o = status_q[`IRQ_DONE_A];
  assign read_done_b_o = status_q[`IRQ_DONE_B];
  assign irq_o = irq_q;
endmodule // ep2_read_ctl

/* File: sim/ep2_properties.sv */
`timescale 1ns/1ps
module ep2_properties
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire logic ep0_clear_feature_rx_i,
  input wire logic ep0_clear_feature_tx_i,
  input wire logic ep0_set_config_i,
  input wire logic usb_reset_i,
  input wire logic stall_handshake_rx_o,
  input wire logic stall_rx_o,
  input wire logic stall_tx_o,
  input wire logic rd_buf_sel_o,
  input wire logic rd_valid_engine_o,
  input wire logic rd_valid_ata_o,
  input wire logic flow_dir_o,
  input wire logic read_done_a_o,
  input wire logic read_done_b_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  logic [3:0] quiet_q;
  wire take = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  wire ctl_wr = take & avs_write_i & avs_byteenable_i[0] & (avs_address_i == 8'hB4);
  wire mapped = avs_address_i inside {8'hB4, 8'hB8, 8'hBC, 8'hC0, 8'hC4};
  wire clr_any = ep0_clear_feature_rx_i | ep0_clear_feature_tx_i | ep0_set_config_i | usb_reset_i;
  // Cycles since a halt-clearing event
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      quiet_q <= 4'h0;
    else if (clr_any)
      quiet_q <= 4'h0;
    else if (quiet_q != 4'hF)
      quiet_q <= quiet_q + 4'h1;
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_gated_wr;
    ctl_wr && avs_writedata_i[1];
  endsequence
  AST_ANSWER: assert property (take |=> s_answer)
    else $error("bus answer timing wrong");
  AST_UNMAPPED: assert property (take && !mapped |=> avs_response_o == 2'b11)
    else $error("unmapped access not refused");
  AST_SEL: assert property (s_gated_wr |=> rd_buf_sel_o == $past(avs_writedata_i[4]))
    else $error("select not applied");
  AST_GATE: assert property (ctl_wr && !avs_writedata_i[1] |=> $stable(rd_buf_sel_o))
    else $error("ungated select applied");
  AST_DIR: assert property (ctl_wr |=> flow_dir_o == $past(avs_writedata_i[7]))
    else $error("direction not applied");
  AST_ROUTE: assert property (rd_valid_engine_o || rd_valid_ata_o |-> flow_dir_o == rd_valid_engine_o)
    else $error("readout routed wrong");
  AST_HALT_RX: assert property (stall_rx_o && quiet_q >= 4'h8 |=> stall_rx_o)
    else $error("receive halt dropped");
  AST_HALT_TX: assert property (stall_tx_o && quiet_q >= 4'h8 |=> stall_tx_o)
    else $error("transmit halt dropped");
  AST_HS_RX: assert property (!stall_rx_o [*2] |-> !stall_handshake_rx_o)
    else $error("stall handshake without halt");
  AST_DONE: assert property (read_done_a_o && !avs_write_i |=> read_done_a_o)
    else $error("done flag lost");
  AST_IRQ: assert property (!read_done_a_o && !read_done_b_o |=> !irq_o)
    else $error("interrupt without status");
endmodule // ep2_properties

bind ep2_read_ctl ep2_properties chk (.*);

/* File: sim/usb_host_model.sv */
`timescale 1ns/1ps
module usb_host_model
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] ev_i,
  input wire logic go_i,
  output logic [7:0] ev_o
);
  logic [1:0] hold_q;
  logic [2:0] kind_q;
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      hold_q <= 2'h0;
      kind_q <= 3'h0;
    end
    else if (go_i)
    begin
      hold_q <= 2'h3;
      kind_q <= ev_i;
    end
    else if (hold_q != 2'h0)
      hold_q <= hold_q - 2'h1;
  assign ev_o = (hold_q != 2'h0) ? (8'h01 << kind_q) : 8'h00;
endmodule // usb_host_model

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic clk_i;
  logic nrst_i = 1'b0;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic en = 1'b0;
  logic rdy = 1'b0;
  logic go = 1'b0;
  logic [2:0] evs = 3'h0;
  logic [7:0] ev;
  logic [31:0] rdata, q;
  logic [1:0] rsp, r, sp, hsk, vld, dn;
  logic wt, sel, dir_o, irq, wtg;
  logic [8:0] addr;
  int n_fail = 0;
  int checked = 0;
  int hs[2] = '{0, 0};
  int m_done[2] = '{0, 0};
  int m_dir = 0, m_sel = 0, m_srx = 0, m_stx = 0, m_en = 0, n, beats;
  usb_host_model host (.clk_i(clk_i), .nrst_i(nrst_i), .ev_i(evs), .go_i(go), .ev_o(ev));
  ep2_read_ctl dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wt),
    .avs_response_o(rsp), .engine_ep_enabled_i(en), .engine_set_stall_rx_i(ev[0]),
    .engine_set_stall_tx_i(ev[1]),
    .ep0_clear_feature_rx_i(ev[2]), .ep0_clear_feature_tx_i(ev[3]), .ep0_set_config_i(ev[4]),
    .usb_reset_i(ev[5]), .token_rx_i(ev[6]), .token_tx_i(ev[7]), .rd_ready_i(rdy),
    .stall_handshake_rx_o(hsk[0]), .stall_handshake_tx_o(hsk[1]), .stall_rx_o(sp[0]), .stall_tx_o(sp[1]),
    .rd_buf_sel_o(sel), .rd_addr_o(addr), .rd_valid_engine_o(vld[1]), .rd_valid_ata_o(vld[0]), .flow_dir_o(dir_o),
    .wr_toggle_o(wtg), .read_done_a_o(dn[0]), .read_done_b_o(dn[1]), .irq_o(irq));
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (hsk[0] === 1'b1) hs[0]++;
    if (hsk[1] === 1'b1) hs[1]++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (wt !== 1'b0 && t < 20);
    if (t == 20) chk(32'h0, 32'h1);
    q = rdata;
    r = rsp;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic fire(input int k);
    evs <= k[2:0];
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  function automatic logic [31:0] ectl();
    return {24'h0, m_dir[0], 2'b00, m_sel[0], m_srx[0], m_stx[0], 1'b0, m_en[0]};
  endfunction
  task automatic test_done;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #2000000;
    n_fail++;
    test_done;
  end
  initial
  begin
    void'($urandom(48707));
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    bus(0, 8'hB4, 0);
    chk(q, 32'h0);
    bus(0, 8'h40, 0);
    chk({q[29:0], r}, 32'h3);
    bus(1, 8'hB4, 32'h10);
    bus(0, 8'hB4, 0);
    chk(q, ectl());
    bus(1, 8'hB4, 32'h60);
    chk_pin(wtg, 1'b1);
    bus(1, 8'hB4, 32'h00);
    chk_pin(wtg, 1'b1);
    bus(1, 8'hB4, 32'h40);
    chk_pin(wtg, 1'b0);
    $display("test reset and gate done");
    for (int i = 0; i < 4; i++)
    begin
      m_dir = $urandom % 2;
      m_sel = i % 2;
      n = $urandom_range(1, 40);
      bus(1, 8'hC0 + 8'(4 * m_sel), n);
      bus(1, 8'hB4, (m_dir << 7) | (m_sel << 4) | 2);
      chk_pin(dn[m_sel], 1'b0);
      beats = 0;
      for (int j = 0; j < 400 && dn[m_sel] !== 1'b1; j++)
      begin
        rdy <= 1'($urandom);
        @(posedge clk_i);
        if (vld[m_dir] === 1'b1 && rdy)
        begin
          chk({23'h0, addr}, beats);
          beats++;
        end
        if (vld[1 - m_dir] === 1'b1) beats += 1000;
      end
      rdy <= 1'b0;
      m_done[m_sel] = 1;
      chk(beats, n);
      chk_pin(sel, m_sel[0]);
      chk_pin(dir_o, m_dir[0]);
      bus(0, 8'hB4, 0);
      chk(q, ectl());
      bus(0, 8'hB8, 0);
      chk(q, {30'h0, m_done[1][0], m_done[0][0]});
    end
    $display("test readout done");
    bus(1, 8'hBC, 1);
    chk_pin(irq, 1'b1);
    bus(1, 8'hB8, 1);
    chk_pin(irq, 1'b0);
    bus(1, 8'hBC, 3);
    chk_pin(irq, 1'b1);
    bus(1, 8'hB8, 2);
    bus(0, 8'hB8, 0);
    chk({q[30:0], irq}, 32'h0);
    $display("test interrupt done");
    en <= 1'b1;
    m_en = 1;
    repeat (6) @(posedge clk_i);
    bus(0, 8'hB4, 0);
    chk(q, ectl());
    for (int s = 0; s < 2; s++)
      for (int e = 0; e < 3; e++)
      begin
        if (e == 0)
          bus(1, 8'hB4, (m_dir << 7) | (8 >> s));
        else
          fire(s);
        bus(1, 8'hB4, m_dir << 7);
        if (s == 0) m_srx = 1;
        else m_stx = 1;
        bus(0, 8'hB4, 0);
        chk(q, ectl());
        chk_pin(sp[s], 1'b1);
        n = hs[s];
        fire(6 + s);
        chk(hs[s], n + 1);
        fire(e == 0 ? 2 + s : 3 + e);
        m_srx = 0;
        m_stx = 0;
        bus(0, 8'hB4, 0);
        chk(q, ectl());
        chk_pin(sp[s], 1'b0);
        fire(6 + s);
        chk(hs[s], n + 1);
      end
    $display("test halt done");
    test_done;
  end
endmodule // tb_top
